// ---- logic/qsr_master.sv ----
// quad serial read master: sequencer, divider, sampler, two-entry buffer
`timescale 1ns/1ps
`include "qsr_defines.svh"

// Contract
// RULE1 - always master, drives clock and select
// RULE2 - reads over one, two or four lanes
// RULE3 - word length one to 128 bits
// RULE4 - one to 4096 words per frame
// RULE5 - three, four or six pin wiring
// RULE6 - optional word or frame completion event
// RULE7 - zero to three periods select-to-data delay
// RULE8 - clock idles low, phase zero
// RULE9 - read data sampled on falling edge
// RULE10 - flash launches data on falling edge
// RULE11 - command line changes on falling edges only
// RULE12 - select active delay+1 periods before fall
// RULE13 - select released two periods after last fall
// RULE14 - command line driven one period before select
// RULE15 - first command change one period before fall
// RULE16 - divider duty even for zero or odd
// RULE17 - a read request fetches data unaided
// RULE18 - select held across all words of frame
module qsr_master (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // read request
  input wire logic req_valid,
  input wire logic [7:0] req_cmd,
  input wire qsr_pkg::qsr_cfg_t req_cfg,
  output logic req_ready_ff,
  // read data out
  output logic rd_valid_ff,
  output logic [127:0] rd_data_ff,
  input wire logic rd_ready,
  // completion events
  output logic word_evt_ff,
  output logic frame_evt_ff,
  // serial pins
  output logic sclk_ff,
  output logic cs_n_ff,
  output logic [3:0] d_out_ff,
  output logic [3:0] d_oe_ff,
  input wire logic [3:0] d_in
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // bits taken per falling edge
  function automatic logic [2:0] lanes(input logic [1:0] m);
    unique case (m)
      `QSR_LANE_TWO: lanes = 3'h2;
      `QSR_LANE_FOUR: lanes = 3'h4;
      default: lanes = 3'h1;
    endcase
  endfunction
  // serial period in ref clocks; zero divide still needs two cycles
  function automatic logic [8:0] per(input logic [7:0] dv);
    per = (dv == 8'h00) ? 9'h002 : {1'b0, dv} + 9'h001;
  endfunction

  qsr_pkg::qsr_cfg_t cfg_ff; // latched setup
  qsr_pkg::qsr_state_t st_ff; // sequencer state
  logic [8:0] cnt_ff; // position inside serial period
  logic [7:0] cmd_ff; // command shifter
  logic [3:0] cbit_ff; // command bits left
  logic [1:0] wait_ff; // setup or tail periods left
  logic [127:0] sh_ff; // incoming word
  logic [7:0] bc_ff; // bits taken in current word
  logic [11:0] wc_ff; // words done in frame
  logic [127:0] ent1_ff; // second buffer entry
  logic v1_ff;
  logic [8:0] p_len;
  logic [8:0] hi_len;
  logic stall;
  logic fall_en;
  logic rise_en;
  logic samp_en;
  logic [127:0] nxt_sh;
  logic word_end;
  logic last_word;
  logic push;
  logic pop;

  // ----------------------------------------
  // serial clock divider
  // ----------------------------------------
  // a nonzero even divide gives high = div/2 cycles, low one more
  assign p_len = per(cfg_ff.serial_clock_divide_ratio); // RULE16
  assign hi_len = p_len >> 1; // RULE16
  // a full buffer parks the clock low so no word is dropped
  assign stall = (st_ff == qsr_pkg::ST_DATA) && v1_ff && rd_valid_ff && (cnt_ff == 9'h000);
  assign fall_en = (st_ff != qsr_pkg::ST_IDLE) && !stall && (cnt_ff == p_len - 9'h001);
  assign rise_en = (st_ff != qsr_pkg::ST_IDLE) && !stall && (cnt_ff == p_len - hi_len - 9'h001);
  assign samp_en = fall_en && (st_ff == qsr_pkg::ST_DATA);

  // period counter runs only inside a frame
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= '0;
    end else if (st_ff == qsr_pkg::ST_IDLE || fall_en) begin
      cnt_ff <= '0;
    end else if (!stall) begin
      cnt_ff <= cnt_ff + 9'h001;
    end
  end

  // clock pulses only while shifting; low at every period edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_ff <= 1'b0;
    end else if (fall_en) begin
      sclk_ff <= 1'b0; // RULE8
    end else if (rise_en && (st_ff == qsr_pkg::ST_CMD || st_ff == qsr_pkg::ST_DATA)) begin
      sclk_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // leaving idle follows the request; every other move happens on a falling edge, so pins stay phase aligned
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= qsr_pkg::ST_IDLE;
      cfg_ff <= '0;
      wait_ff <= '0;
    end else begin
      unique case (st_ff)
        qsr_pkg::ST_IDLE: begin
          // the port only ever starts frames itself
          if (req_valid) begin // RULE1 RULE17
            cfg_ff <= req_cfg;
            st_ff <= qsr_pkg::ST_LEAD;
          end
        end
        qsr_pkg::ST_LEAD: begin
          if (fall_en) begin
            wait_ff <= cfg_ff.cs_to_clock_delay_count;
            // zero delay goes straight to the first clock period
            st_ff <= (cfg_ff.cs_to_clock_delay_count == 2'h0) ? qsr_pkg::ST_CMD : qsr_pkg::ST_SETUP; // RULE7
          end
        end
        qsr_pkg::ST_SETUP: begin
          if (fall_en) begin
            wait_ff <= wait_ff - 2'h1;
            if (wait_ff == 2'h1) begin // RULE12
              st_ff <= qsr_pkg::ST_CMD;
            end
          end
        end
        qsr_pkg::ST_CMD: begin
          if (fall_en && cbit_ff == 4'h1) begin
            st_ff <= qsr_pkg::ST_DATA;
          end
        end
        qsr_pkg::ST_DATA: begin
          if (word_end && last_word) begin
            wait_ff <= `QSR_TAIL_PER; // RULE13
            st_ff <= qsr_pkg::ST_TAIL;
          end
        end
        qsr_pkg::ST_TAIL: begin
          if (fall_en) begin
            wait_ff <= wait_ff - 2'h1;
            if (wait_ff == 2'h1) begin
              st_ff <= qsr_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ready only between frames
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      req_ready_ff <= 1'b0;
    end else begin
      req_ready_ff <= (st_ff == qsr_pkg::ST_IDLE) && !req_valid;
    end
  end

  // ----------------------------------------
  // select and command line
  // ----------------------------------------
  // select falls at end of lead, rises at end of tail
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cs_n_ff <= 1'b1;
    end else if (fall_en && st_ff == qsr_pkg::ST_LEAD) begin
      cs_n_ff <= 1'b0; // RULE12
    end else if (fall_en && st_ff == qsr_pkg::ST_TAIL && wait_ff == 2'h1) begin
      cs_n_ff <= 1'b1; // RULE13 RULE18
    end
  end

  // command shifts msb first; first bit appears one period before first fall
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmd_ff <= '0;
      cbit_ff <= '0;
      d_out_ff <= '0;
    end else if (st_ff == qsr_pkg::ST_IDLE && req_valid) begin
      cmd_ff <= req_cmd;
      cbit_ff <= `QSR_CMD_BITS;
      d_out_ff <= '0;
    end else if (fall_en) begin
      if ((st_ff == qsr_pkg::ST_LEAD && cfg_ff.cs_to_clock_delay_count == 2'h0) ||
          (st_ff == qsr_pkg::ST_SETUP && wait_ff == 2'h1)) begin
        d_out_ff[0] <= cmd_ff[`QSR_CMD_TOP]; // RULE15
        cmd_ff <= {cmd_ff[6:0], 1'b0};
      end else if (st_ff == qsr_pkg::ST_CMD) begin
        // later bits change only at falling edges
        d_out_ff[0] <= (cbit_ff == 4'h1) ? 1'b0 : cmd_ff[`QSR_CMD_TOP]; // RULE11
        cmd_ff <= {cmd_ff[6:0], 1'b0};
        cbit_ff <= cbit_ff - 4'h1;
      end
    end
  end

  // d0 driven from lead on; released when it becomes a read lane
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      d_oe_ff <= '0;
    end else if (st_ff == qsr_pkg::ST_IDLE) begin
      d_oe_ff <= {3'h0, req_valid}; // RULE14
    end else if (fall_en && st_ff == qsr_pkg::ST_CMD && cbit_ff == 4'h1) begin
      // upper lanes are never driven: read-only port
      d_oe_ff <= {3'h0, cfg_ff.lane_mode == `QSR_LANE_ONE && cfg_ff.pin_mode != `QSR_PIN_THREE}; // RULE5
    end else if (fall_en && st_ff == qsr_pkg::ST_TAIL && wait_ff == 2'h1) begin
      d_oe_ff <= '0;
    end
  end

  // ----------------------------------------
  // read sampler
  // ----------------------------------------
  // single lane reads d1, or d0 when wired as three pins
  always_comb begin
    nxt_sh = sh_ff;
    unique case (cfg_ff.lane_mode)
      `QSR_LANE_TWO: nxt_sh = {sh_ff[125:0], d_in[1:0]};
      `QSR_LANE_FOUR: nxt_sh = {sh_ff[123:0], d_in[3:0]};
      default: nxt_sh = {sh_ff[126:0], (cfg_ff.pin_mode == `QSR_PIN_THREE) ? d_in[0] : d_in[1]};
    endcase
  end

  // a word ends once its programmed length is reached
  assign word_end = samp_en && ({1'b0, bc_ff} + {5'h00, lanes(cfg_ff.lane_mode)} > {2'h0, cfg_ff.word_len_m1}); // RULE3
  assign last_word = (wc_ff == cfg_ff.word_cnt_m1); // RULE4

  // sample only at falling edges; the flash moved its data at the one before
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sh_ff <= '0;
    end else if (samp_en) begin
      sh_ff <= nxt_sh; // RULE9 RULE10 RULE2
    end
  end

  // bit and word counters
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bc_ff <= '0;
      wc_ff <= '0;
    end else if (st_ff == qsr_pkg::ST_IDLE) begin
      bc_ff <= '0;
      wc_ff <= '0;
    end else if (word_end) begin
      bc_ff <= '0;
      wc_ff <= wc_ff + 12'h001; // RULE18
    end else if (samp_en) begin
      bc_ff <= bc_ff + {5'h00, lanes(cfg_ff.lane_mode)};
    end
  end

  // completion events, one cycle each, when enabled
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      word_evt_ff <= 1'b0;
      frame_evt_ff <= 1'b0;
    end else begin
      word_evt_ff <= word_end && cfg_ff.word_ie; // RULE6
      frame_evt_ff <= word_end && last_word && cfg_ff.frame_ie; // RULE6
    end
  end

  // ----------------------------------------
  // two-entry buffer
  // ----------------------------------------
  // head entry is the output; stall keeps push from meeting a full pair
  assign push = word_end;
  assign pop = rd_valid_ff && rd_ready;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
      v1_ff <= 1'b0;
      ent1_ff <= '0;
    end else begin
      if (!rd_valid_ff || pop) begin
        // head refills from second entry first, then from the sampler
        rd_valid_ff <= v1_ff || push;
        rd_data_ff <= v1_ff ? ent1_ff : nxt_sh;
        v1_ff <= v1_ff && push;
        ent1_ff <= nxt_sh;
      end else if (push) begin
        v1_ff <= 1'b1;
        ent1_ff <= nxt_sh;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_idle_quiet;
    @(posedge ref_clk) disable iff (reset)
      st_ff == qsr_pkg::ST_IDLE |-> cs_n_ff && !sclk_ff && d_oe_ff == 4'h0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pins active while idle"); // RULE1

  property p_clk_low;
    @(posedge ref_clk) disable iff (reset)
      (st_ff == qsr_pkg::ST_LEAD || st_ff == qsr_pkg::ST_SETUP || st_ff == qsr_pkg::ST_TAIL) |-> !sclk_ff;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock high outside shifting"); // RULE8

  property p_cmd_fall;
    @(posedge ref_clk) disable iff (reset)
      ($past(st_ff) == qsr_pkg::ST_CMD) && $changed(d_out_ff[0]) |-> $fell(sclk_ff);
  endproperty
  a_cmd_fall: assert property (p_cmd_fall) else $error("command moved off falling edge"); // RULE11

  property p_samp_fall;
    @(posedge ref_clk) disable iff (reset)
      $changed(sh_ff) |-> $fell(sclk_ff);
  endproperty
  a_samp_fall: assert property (p_samp_fall) else $error("sample off falling edge"); // RULE9

  property p_lead_oe;
    @(posedge ref_clk) disable iff (reset)
      $fell(cs_n_ff) |-> $past(d_oe_ff[0], 2);
  endproperty
  a_lead_oe: assert property (p_lead_oe) else $error("d0 not driven before select"); // RULE14

  property p_hold_cs;
    @(posedge ref_clk) disable iff (reset)
      (st_ff == qsr_pkg::ST_CMD || st_ff == qsr_pkg::ST_DATA) |-> !cs_n_ff;
  endproperty
  a_hold_cs: assert property (p_hold_cs) else $error("select dropped mid frame"); // RULE18

  property p_tail_end;
    @(posedge ref_clk) disable iff (reset)
      fall_en && st_ff == qsr_pkg::ST_TAIL && wait_ff == 2'h1 |=> cs_n_ff && st_ff == qsr_pkg::ST_IDLE;
  endproperty
  a_tail_end: assert property (p_tail_end) else $error("select not released after tail"); // RULE13

  property p_upper_in;
    @(posedge ref_clk) disable iff (reset)
      d_oe_ff[3:1] == 3'h0;
  endproperty
  a_upper_in: assert property (p_upper_in) else $error("upper lane driven"); // RULE5

  property p_evt;
    @(posedge ref_clk) disable iff (reset)
      frame_evt_ff |-> $past(word_end) && cfg_ff.frame_ie ##1 st_ff == qsr_pkg::ST_TAIL;
  endproperty
  a_evt: assert property (p_evt) else $error("frame event without frame end"); // RULE6

  c_frame: cover property (@(posedge ref_clk) disable iff (reset) $rose(cs_n_ff));
  c_stall: cover property (@(posedge ref_clk) disable iff (reset) stall);
  c_quad: cover property (@(posedge ref_clk) disable iff (reset) samp_en && cfg_ff.lane_mode == `QSR_LANE_FOUR);
endmodule

// ---- logic/qsr_defines.svh ----
// named constants for the quad serial read master
`ifndef QSR_DEFINES_SVH
`define QSR_DEFINES_SVH
`define QSR_CMD_BITS 4'h8
`define QSR_CMD_TOP 3'h7
`define QSR_TAIL_PER 2'h2
`define QSR_LANE_ONE 2'h0
`define QSR_LANE_TWO 2'h1
`define QSR_LANE_FOUR 2'h2
`define QSR_PIN_THREE 2'h0
`define QSR_PIN_FOUR 2'h1
`define QSR_PIN_SIX 2'h2
`define QSR_WORD_MAX 7'h7f
`endif

// ---- logic/qsr_pkg.sv ----
// types shared by the quad serial read master
package qsr_pkg;
  // transfer setup, latched when a read is taken
  typedef struct packed {
    logic [7:0] serial_clock_divide_ratio;
    logic [1:0] cs_to_clock_delay_count;
    logic [1:0] lane_mode;
    logic [1:0] pin_mode;
    logic [6:0] word_len_m1;
    logic [11:0] word_cnt_m1;
    logic word_ie;
    logic frame_ie;
  } qsr_cfg_t;
  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LEAD = 6'h02,
    ST_SETUP = 6'h04,
    ST_CMD = 6'h08,
    ST_DATA = 6'h10,
    ST_TAIL = 6'h20
  } qsr_state_t;
endpackage

// ---- tb/qsr_flash_model.sv ----
// behavioural serial flash that answers the quad serial read master
`timescale 1ns/1ps
module qsr_flash_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // pins from the master
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] d_out,
  input wire logic [3:0] d_oe,
  // resolved lane levels and the command seen
  output logic [3:0] d_in,
  output logic [7:0] cmd_seen_ff
);
  logic sclk_d_ff; // clock one cycle back, for edge detection
  logic [11:0] fall_cnt_ff; // falls seen in this frame
  logic [3:0] drv_ff; // level the flash puts on its lanes

  // data pattern, a function of the command and the fall number
  function automatic logic [3:0] nib(input logic [7:0] c, input logic [11:0] k);
    return c[3:0] ^ k[3:0] ^ k[7:4] ^ {k[1:0], k[9:8]};
  endfunction

  // command shifted in on rises, data launched on falls
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclk_d_ff <= 1'b0;
      fall_cnt_ff <= 12'h000;
      drv_ff <= 4'h0;
      cmd_seen_ff <= 8'h00;
    end else begin
      sclk_d_ff <= sclk;
      if (cs_n) begin
        // not selected: toggle so a stale bit can never pass for data
        fall_cnt_ff <= 12'h000;
        drv_ff <= ~drv_ff;
      end else if (sclk && !sclk_d_ff && fall_cnt_ff < 12'h008) begin
        cmd_seen_ff <= {cmd_seen_ff[6:0], d_in[0]};
      end else if (!sclk && sclk_d_ff) begin
        fall_cnt_ff <= fall_cnt_ff + 12'h001;
        if (fall_cnt_ff >= 12'h007) begin
          drv_ff <= nib(cmd_seen_ff, fall_cnt_ff + 12'h001);
        end
      end
    end
  end

  // a lane the master drives wins, otherwise the flash level shows
  assign d_in = (d_oe & d_out) | (~d_oe & drv_ff);
endmodule

// ---- tb/tb_qsr_master.sv ----
// self-checking bench for the quad serial read master
`timescale 1ns/1ps
`include "qsr_defines.svh"
module tb_qsr_master;
  // ----------------------------------------
  // stimulus, design and flash
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic [7:0] req_cmd = 8'h00;
  qsr_pkg::qsr_cfg_t req_cfg = '0;
  logic rd_ready = 1'b0;
  logic req_ready_ff, rd_valid_ff, word_evt_ff, frame_evt_ff, sclk_ff, cs_n_ff;
  logic [127:0] rd_data_ff;
  logic [3:0] d_out_ff, d_oe_ff, d_in;
  logic [7:0] cmd_seen;
  logic p_sc = 1'b0, p_cs = 1'b1, p_oe = 1'b0, p_d0 = 1'b0; // pins one cycle back
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0, per = 2, t_oe = 0, t_cs = 0, t_d = 0, t_f1 = 0, t_fl = 0, hi = 0, n_w = 0, n_f = 0, n_cs = 0;

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  qsr_master qsr_master_i (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_cfg(req_cfg), .req_ready_ff(req_ready_ff), .rd_valid_ff(rd_valid_ff), .rd_data_ff(rd_data_ff),
    .rd_ready(rd_ready), .word_evt_ff(word_evt_ff), .frame_evt_ff(frame_evt_ff), .sclk_ff(sclk_ff),
    .cs_n_ff(cs_n_ff), .d_out_ff(d_out_ff), .d_oe_ff(d_oe_ff), .d_in(d_in));
  qsr_flash_model qsr_flash_model_i (.ref_clk(ref_clk), .reset(reset), .sclk(sclk_ff), .cs_n(cs_n_ff),
    .d_out(d_out_ff), .d_oe(d_oe_ff), .d_in(d_in), .cmd_seen_ff(cmd_seen));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // same pattern the flash launches, worked out independently
  function automatic logic [3:0] nib(input logic [7:0] c, input logic [11:0] k);
    return c[3:0] ^ k[3:0] ^ k[7:4] ^ {k[1:0], k[9:8]};
  endfunction

  // word j as the lanes carry it, msb first; first data launch is fall 8
  function automatic logic [127:0] exp_word(input logic [7:0] c, input qsr_pkg::qsr_cfg_t g, input int j);
    logic [127:0] w;
    logic [3:0] n;
    int b;
    int f;
    b = (g.lane_mode == `QSR_LANE_FOUR) ? 4 : (g.lane_mode == `QSR_LANE_TWO) ? 2 : 1;
    f = (g.word_len_m1 + 1) / b;
    w = '0;
    for (int i = 0; i < f; i++) begin
      n = nib(c, 12'(8 + j * f + i));
      if (b == 4) w = {w[123:0], n};
      else if (b == 2) w = {w[125:0], n[1:0]};
      else w = {w[126:0], (g.pin_mode == `QSR_PIN_THREE) ? n[0] : n[1]};
    end
    return w;
  endfunction

  // one frame: request, drain words with a moody receiver, then tally
  task automatic run_frame(input qsr_pkg::qsr_cfg_t g, input logic [7:0] cmd, input int stall);
    int got;
    logic [127:0] mask;
    got = 0;
    mask = {128{1'b1}} >> (7'h7f - g.word_len_m1);
    while (req_ready_ff !== 1'b1) @(negedge ref_clk);
    // top bit opposite to the idle lane so the first change is visible
    cmd[7] = ~d_out_ff[0];
    per = (g.serial_clock_divide_ratio == 8'h00) ? 2 : g.serial_clock_divide_ratio + 1;
    req_cfg = g;
    req_cmd = cmd;
    req_valid = 1'b1;
    n_w = 0;
    n_f = 0;
    n_cs = 0;
    @(negedge ref_clk);
    req_valid = 1'b0;
    while (got <= g.word_cnt_m1) begin
      @(negedge ref_clk);
      rd_ready = (stall > 0) ? 1'b0 : 1'($urandom % 2);
      stall--;
      if (rd_ready && rd_valid_ff === 1'b1) begin
        check(rd_data_ff & mask, exp_word(cmd, g, got));
        got++;
      end
    end
    while (cs_n_ff !== 1'b1) @(negedge ref_clk);
    rd_ready = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(cmd_seen, cmd);
    check(n_w, g.word_ie ? g.word_cnt_m1 + 1 : 0);
    check(n_f, g.frame_ie);
    check(n_cs, 1);
  endtask

  // ----------------------------------------
  // pin timing monitor, in cycles of ref_clk
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (!reset) begin
      if (word_evt_ff === 1'b1) n_w++;
      if (frame_evt_ff === 1'b1) n_f++;
      if (cs_n_ff === 1'b1) check(sclk_ff, 1'b0);
      if (d_oe_ff[0] === 1'b1 && p_oe !== 1'b1) t_oe = cyc;
      if (cs_n_ff === 1'b0 && p_cs === 1'b1) begin
        t_cs = cyc;
        t_d = 0;
        t_f1 = 0;
      end
      // the first command bit is exempt: it leads the first fall
      if (cs_n_ff === 1'b0 && d_oe_ff[0] === 1'b1 && d_out_ff[0] !== p_d0) begin
        if (t_d == 0) t_d = cyc;
        else check({p_sc, sclk_ff}, 2'b10);
      end
      if (p_sc === 1'b1 && sclk_ff === 1'b0) begin
        check(hi, per / 2);
        if (t_f1 == 0) t_f1 = cyc;
        t_fl = cyc;
      end
      hi = (sclk_ff === 1'b1) ? hi + 1 : 0;
      if (cs_n_ff === 1'b1 && p_cs === 1'b0) begin
        n_cs++;
        check(t_cs - t_oe, per);
        check(t_f1 - t_cs, (req_cfg.cs_to_clock_delay_count + 1) * per);
        check(t_f1 - t_d, per);
        check(cyc - t_fl, 2 * per);
      end
    end
    p_sc = sclk_ff;
    p_cs = cs_n_ff;
    p_oe = d_oe_ff[0];
    p_d0 = d_out_ff[0];
  end

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    qsr_pkg::qsr_cfg_t g;
    int b;
    void'($urandom(32'hd3d0));
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    g = '0;
    run_frame(g, 8'h00, 0); // one bit, one lane, three pins, no delay
    g = '{8'h02, 2'h3, `QSR_LANE_FOUR, `QSR_PIN_SIX, 7'h7f, 12'h002, 1'b1, 1'b1};
    run_frame(g, 8'h5a, 1000); // widest words, even divider, receiver stalls
    for (int k = 0; k < 16; k++) begin
      g.serial_clock_divide_ratio = 8'($urandom % 5);
      g.cs_to_clock_delay_count = 2'($urandom);
      g.lane_mode = 2'($urandom % 3);
      g.pin_mode = (g.lane_mode == `QSR_LANE_FOUR) ? `QSR_PIN_SIX : 2'(g.lane_mode + $urandom % (3 - g.lane_mode));
      b = (g.lane_mode == `QSR_LANE_FOUR) ? 4 : (g.lane_mode == `QSR_LANE_TWO) ? 2 : 1;
      g.word_len_m1 = 7'(b * (1 + $urandom % (128 / b)) - 1);
      g.word_cnt_m1 = 12'($urandom % 3);
      g.word_ie = 1'($urandom);
      g.frame_ie = 1'($urandom);
      run_frame(g, 8'($urandom), 0);
    end
    results();
  end

  // a hang ends the run as a failure
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    results();
  end
endmodule
